// *** hw/dstw_top.v ***
// Dual-slope timer waveform generator with APB register slave
`timescale 1ns/1ps
`include "dstw_defs.vh"

// Notes on behaviour
// R1: Waveform modes 8 and 9 count up from zero to TOP, then down.
// R2: Mode 8 takes TOP from capture register, mode 9 from compare A.
// R3: The counter stays at TOP for one tick before counting down.
// R4: TOP may be anything from 0x0003 up to 0xffff.
// R5: Output mode 2 dual-slope: clear on up match, set on down match.
// R6: Output mode 3 dual-slope: set on up match, clear on down match.
// R7: Phase-frequency mode loads compare buffers and sets overflow at BOTTOM.
// R8: At TOP set compare-A flag or capture flag, per TOP source.
// R9: Each unit flags a match when count equals its active compare value.
// R10: Compare values above TOP never match; software keeps TOP high enough.
// R11: Mode 9 with output mode 1 toggles output A, square wave.
// R12: Dual-slope compare zero holds PWM low, compare TOP holds high; inverted opposite.
// R13: Output modes 2 and 3, and 1 where it toggles, hand pin to waveform; direction bit enables drive.
// R14: Output mode zero keeps normal port function in every mode.
// R15: Non-PWM modes: output mode 1, 2, 3 toggle, clear, set on match.
// R16: Fast PWM: 2 clears on match sets at BOTTOM, 3 reverse; toggle mode 15.
// R17: Fast PWM ignores match at TOP but still acts at BOTTOM.
// R18: Dual-slope output mode 1 toggles A in mode 9 only.
// R19: All counting runs on one clock; tick is only an enable.
// R20: Tick divides the clock by 1, 8, 64, 256 or 1024.
// R21: Software changing frequency at run time should use compare A as TOP.
// R22: Clock select 0 stops, 1-5 divide, 6-7 external falling/rising edge.
// R23: Force strobes act only in non-PWM modes, no flag, no clear.
// R24: After zero while counting down, count up on the next tick.
module dstw_top (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // APB slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire [31:0] o_prdata,
  output wire o_pready,
  output wire o_pslverr,
  // External tick source
  input wire i_ext_clk,
  // Output compare pins
  output wire o_wave_pin_a,
  output wire o_wave_pin_a_oe_n,
  output wire o_wave_pin_b,
  output wire o_wave_pin_b_oe_n
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [7:0] ctrl_a_reg;
  reg [1:0] wgm_hi_reg;
  reg [2:0] clock_select_reg;
  reg [15:0] count_reg;
  reg [15:0] count_next;
  reg dir_down_reg;
  reg dir_down_next;
  reg [15:0] cmp_buf_a_reg;
  reg [15:0] cmp_buf_b_reg;
  reg [15:0] compare_reg_a;
  reg [15:0] compare_reg_b;
  reg [15:0] capture_reg;
  reg [3:0] flag_reg;
  reg [1:0] pin_dir_reg;
  reg [1:0] port_data_reg;
  reg [31:0] prdata_reg;
  reg [31:0] prdata_next;
  reg pready_reg;
  reg pslverr_reg;
  reg addr_hit;
  reg pin_a_reg;
  reg pin_b_reg;
  reg pin_a_oe_n_reg;
  reg pin_b_oe_n_reg;

  // Mode decode
  reg [15:0] top_val;
  reg is_dual;
  reg is_pfc;
  reg is_fast;
  reg is_nonpwm;
  reg top_from_capt;
  reg top_from_cmp_a;
  reg is_normal;

  // Counter events
  reg top_ev;
  reg bot_ev;
  reg tov_ev;
  reg upd_ev;

  wire tick;
  wire [3:0] waveform_mode;
  wire [1:0] out_mode_a;
  wire [1:0] out_mode_b;
  wire wr_en;
  wire at_top;
  wire at_bottom;
  wire up_ctx;
  wire [1:0] match;
  wire [1:0] force_cmp;
  wire [1:0] tog_ok;
  wire [1:0] eq_top;
  wire [1:0] wave;
  wire [1:0] connected;
  wire [1:0] omode [0:1];
  wire [3:0] flag_set;
  wire [3:0] flag_clr;

  assign waveform_mode = {wgm_hi_reg, ctrl_a_reg[1:0]};
  assign out_mode_a = ctrl_a_reg[7:6];
  assign out_mode_b = ctrl_a_reg[5:4];
  assign omode[0] = out_mode_a;
  assign omode[1] = out_mode_b;

  assign o_prdata = prdata_reg;
  assign o_pready = pready_reg;
  assign o_pslverr = pslverr_reg;
  assign o_wave_pin_a = pin_a_reg;
  assign o_wave_pin_b = pin_b_reg;
  assign o_wave_pin_a_oe_n = pin_a_oe_n_reg;
  assign o_wave_pin_b_oe_n = pin_b_oe_n_reg;

  // ----------------------------------------------------------------
  // Tick source
  // ----------------------------------------------------------------
  dstw_prescaler u_prescaler (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_clock_select(clock_select_reg),
    .i_ext_clk(i_ext_clk),
    .o_tick(tick)
  );

  // ----------------------------------------------------------------
  // Waveform mode decode
  // ----------------------------------------------------------------
  always @* begin
    top_val = `DSTW_TOP_MAX;
    is_dual = 1'b0;
    is_pfc = 1'b0;
    is_fast = 1'b0;
    is_nonpwm = 1'b0;
    top_from_capt = 1'b0;
    top_from_cmp_a = 1'b0;
    is_normal = 1'b0;
    case (waveform_mode)
      4'h1: begin
        is_dual = 1'b1;
        top_val = `DSTW_TOP_8BIT;
      end
      4'h2: begin
        is_dual = 1'b1;
        top_val = `DSTW_TOP_9BIT;
      end
      4'h3: begin
        is_dual = 1'b1;
        top_val = `DSTW_TOP_10BIT;
      end
      4'h4: begin
        is_nonpwm = 1'b1;
        top_from_cmp_a = 1'b1;
      end
      4'h5: begin
        is_fast = 1'b1;
        top_val = `DSTW_TOP_8BIT;
      end
      4'h6: begin
        is_fast = 1'b1;
        top_val = `DSTW_TOP_9BIT;
      end
      4'h7: begin
        is_fast = 1'b1;
        top_val = `DSTW_TOP_10BIT;
      end
      4'h8, 4'ha: begin
        is_dual = 1'b1; // R1
        is_pfc = (waveform_mode == 4'h8);
        top_from_capt = 1'b1; // R2
      end
      4'h9, 4'hb: begin
        is_dual = 1'b1; // R1
        is_pfc = (waveform_mode == 4'h9);
        top_from_cmp_a = 1'b1; // R2
      end
      4'hc: begin
        is_nonpwm = 1'b1;
        top_from_capt = 1'b1;
      end
      4'he: begin
        is_fast = 1'b1;
        top_from_capt = 1'b1;
      end
      4'hf: begin
        is_fast = 1'b1;
        top_from_cmp_a = 1'b1;
      end
      default: begin
        // Mode 0 and the reserved code run as a plain counter
        is_nonpwm = 1'b1;
        is_normal = 1'b1;
      end
    endcase
    if (top_from_capt) begin
      top_val = capture_reg; // R2 R4
    end else if (top_from_cmp_a) begin
      top_val = compare_reg_a; // R2 R4
    end
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  assign at_top = (count_reg >= top_val);
  assign at_bottom = (count_reg == 16'h0000);
  assign up_ctx = (~dir_down_reg & ~at_top) | at_bottom;

  always @* begin
    count_next = count_reg;
    dir_down_next = dir_down_reg;
    top_ev = 1'b0;
    bot_ev = 1'b0;
    if (tick) begin // R19
      if (is_dual) begin
        if (!dir_down_reg) begin
          if (at_top) begin
            dir_down_next = 1'b1; // R2 R3
            count_next = count_reg - 16'h0001;
            top_ev = 1'b1;
          end else begin
            count_next = count_reg + 16'h0001; // R1
          end
        end else if (at_bottom) begin
          dir_down_next = 1'b0; // R24
          count_next = 16'h0001;
          bot_ev = 1'b1;
        end else begin
          count_next = count_reg - 16'h0001; // R1
        end
      end else begin
        dir_down_next = 1'b0;
        if (!is_normal && at_top) begin
          count_next = 16'h0000;
          top_ev = 1'b1;
        end else begin
          count_next = count_reg + 16'h0001;
        end
      end
    end
    if (wr_en && i_paddr == `DSTW_ADDR_COUNT) begin
      // Software write wins over the tick
      count_next = i_pwdata[15:0];
    end
    if (is_dual) begin
      tov_ev = bot_ev;
    end else if (is_fast) begin
      tov_ev = top_ev;
    end else begin
      tov_ev = tick && (count_reg == `DSTW_TOP_MAX);
    end
    if (is_nonpwm) begin
      upd_ev = 1'b1;
    end else if (is_pfc) begin
      upd_ev = bot_ev; // R7
    end else if (is_dual) begin
      upd_ev = top_ev;
    end else begin
      upd_ev = top_ev;
    end
  end

  // ----------------------------------------------------------------
  // Compare units
  // ----------------------------------------------------------------
  assign match[0] = tick && (count_reg == compare_reg_a) && (compare_reg_a <= top_val); // R9 R10
  assign match[1] = tick && (count_reg == compare_reg_b) && (compare_reg_b <= top_val); // R9 R10
  assign eq_top[0] = (compare_reg_a == top_val);
  assign eq_top[1] = (compare_reg_b == top_val);
  assign tog_ok[0] = is_nonpwm || waveform_mode == 4'hf ||
                     waveform_mode == 4'h9; // R16 R18
  assign tog_ok[1] = is_nonpwm; // R18
  assign force_cmp[0] = wr_en && i_paddr == `DSTW_ADDR_CTRL_A && i_pwdata[`DSTW_CA_FORCE_A];
  assign force_cmp[1] = wr_en && i_paddr == `DSTW_ADDR_CTRL_A && i_pwdata[`DSTW_CA_FORCE_B];

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_unit
      dstw_wave_unit u_wave (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_out_mode(omode[gi]),
        .i_tog_ok(tog_ok[gi]),
        .i_nonpwm(is_nonpwm),
        .i_fast(is_fast),
        .i_dual(is_dual),
        .i_match(match[gi]),
        .i_up_ctx(up_ctx),
        .i_bottom(top_ev & is_fast),
        .i_ocr_eq_top(eq_top[gi]),
        .i_force(force_cmp[gi] & is_nonpwm),
        .o_wave(wave[gi]),
        .o_connected(connected[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Flags: a set in the same cycle as a clear wins
  // ----------------------------------------------------------------
  assign flag_set[`DSTW_FLG_OVF] = tov_ev; // R7
  assign flag_set[`DSTW_FLG_CMP_A] = match[0]; // R8 R9
  assign flag_set[`DSTW_FLG_CMP_B] = match[1]; // R9
  assign flag_set[`DSTW_FLG_CAPT] = top_ev & top_from_capt; // R8
  assign flag_clr = (wr_en && i_paddr == `DSTW_ADDR_FLAGS) ? i_pwdata[3:0] : 4'h0;

  // ----------------------------------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------------------------------
  assign wr_en = i_psel & i_penable & pready_reg & i_pwrite;

  always @* begin
    addr_hit = 1'b1;
    prdata_next = 32'h00000000;
    if (i_paddr == `DSTW_ADDR_CTRL_A) begin
      // Force bits always read as zero
      prdata_next[7:0] = {ctrl_a_reg[7:4], 2'h0, ctrl_a_reg[1:0]};
    end else if (i_paddr == `DSTW_ADDR_CTRL_B) begin
      prdata_next[4:0] = {wgm_hi_reg, clock_select_reg};
    end else if (i_paddr == `DSTW_ADDR_COUNT) begin
      prdata_next[15:0] = count_reg;
    end else if (i_paddr == `DSTW_ADDR_CMP_A) begin
      prdata_next[15:0] = cmp_buf_a_reg;
    end else if (i_paddr == `DSTW_ADDR_CMP_B) begin
      prdata_next[15:0] = cmp_buf_b_reg;
    end else if (i_paddr == `DSTW_ADDR_CAPT) begin
      prdata_next[15:0] = capture_reg;
    end else if (i_paddr == `DSTW_ADDR_FLAGS) begin
      prdata_next[4:0] = {dir_down_reg, flag_reg};
    end else if (i_paddr == `DSTW_ADDR_PORT) begin
      prdata_next[3:0] = {port_data_reg, pin_dir_reg};
    end else begin
      addr_hit = 1'b0;
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= i_psel & ~i_penable;
      if (i_psel && !i_penable) begin
        prdata_reg <= i_pwrite ? 32'h00000000 : prdata_next;
        pslverr_reg <= ~addr_hit;
      end else begin
        pslverr_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_a_reg <= `DSTW_RST_CTRL_A;
      wgm_hi_reg <= 2'h0;
      clock_select_reg <= `DSTW_CS_STOP;
      count_reg <= `DSTW_RST_WORD;
      dir_down_reg <= 1'b0;
      cmp_buf_a_reg <= `DSTW_RST_WORD;
      cmp_buf_b_reg <= `DSTW_RST_WORD;
      compare_reg_a <= `DSTW_RST_WORD;
      compare_reg_b <= `DSTW_RST_WORD;
      capture_reg <= `DSTW_RST_WORD;
      flag_reg <= 4'h0;
      pin_dir_reg <= 2'h0;
      port_data_reg <= 2'h0;
    end else begin
      count_reg <= count_next;
      dir_down_reg <= dir_down_next;
      flag_reg <= (flag_reg & ~flag_clr) | flag_set;
      if (upd_ev) begin
        compare_reg_a <= cmp_buf_a_reg; // R7
        compare_reg_b <= cmp_buf_b_reg; // R7
      end
      if (wr_en) begin
        if (i_paddr == `DSTW_ADDR_CTRL_A) begin
          ctrl_a_reg <= {i_pwdata[7:4], 2'h0, i_pwdata[1:0]};
        end else if (i_paddr == `DSTW_ADDR_CTRL_B) begin
          wgm_hi_reg <= i_pwdata[4:3];
          clock_select_reg <= i_pwdata[2:0]; // R22
        end else if (i_paddr == `DSTW_ADDR_CMP_A) begin
          cmp_buf_a_reg <= i_pwdata[15:0];
        end else if (i_paddr == `DSTW_ADDR_CMP_B) begin
          cmp_buf_b_reg <= i_pwdata[15:0];
        end else if (i_paddr == `DSTW_ADDR_CAPT) begin
          capture_reg <= i_pwdata[15:0];
        end else if (i_paddr == `DSTW_ADDR_PORT) begin
          pin_dir_reg <= i_pwdata[1:0];
          port_data_reg <= i_pwdata[3:2];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_a_reg <= 1'b0;
      pin_b_reg <= 1'b0;
      pin_a_oe_n_reg <= 1'b1;
      pin_b_oe_n_reg <= 1'b1;
    end else begin
      pin_a_reg <= connected[0] ? wave[0] : port_data_reg[0]; // R13 R14
      pin_b_reg <= connected[1] ? wave[1] : port_data_reg[1]; // R13 R14
      pin_a_oe_n_reg <= ~pin_dir_reg[0]; // R13
      pin_b_oe_n_reg <= ~pin_dir_reg[1]; // R13
    end
  end

endmodule

// *** hw/dstw_defs.vh ***
// Constants for the dual-slope timer waveform generator
`ifndef DSTW_DEFS_VH
`define DSTW_DEFS_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define DSTW_ADDR_CTRL_A 8'h00
`define DSTW_ADDR_CTRL_B 8'h04
`define DSTW_ADDR_COUNT 8'h08
`define DSTW_ADDR_CMP_A 8'h0c
`define DSTW_ADDR_CMP_B 8'h10
`define DSTW_ADDR_CAPT 8'h14
`define DSTW_ADDR_FLAGS 8'h18
`define DSTW_ADDR_PORT 8'h1c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DSTW_CA_FORCE_A 3
`define DSTW_CA_FORCE_B 2
`define DSTW_FLG_OVF 0
`define DSTW_FLG_CMP_A 1
`define DSTW_FLG_CMP_B 2
`define DSTW_FLG_CAPT 3

// ----------------------------------------------------------------
// Reset values and fixed counts
// ----------------------------------------------------------------
`define DSTW_RST_CTRL_A 8'h00
`define DSTW_RST_WORD 16'h0000
`define DSTW_TOP_MAX 16'hffff
`define DSTW_TOP_8BIT 16'h00ff
`define DSTW_TOP_9BIT 16'h01ff
`define DSTW_TOP_10BIT 16'h03ff
`define DSTW_DIV_8 10'h007
`define DSTW_DIV_64 10'h03f
`define DSTW_DIV_256 10'h0ff
`define DSTW_DIV_1024 10'h3ff

// ----------------------------------------------------------------
// Clock select codes
// ----------------------------------------------------------------
`define DSTW_CS_STOP 3'h0
`define DSTW_CS_DIV1 3'h1
`define DSTW_CS_DIV8 3'h2
`define DSTW_CS_DIV64 3'h3
`define DSTW_CS_DIV256 3'h4
`define DSTW_CS_DIV1024 3'h5
`define DSTW_CS_EXT_FALL 3'h6
`define DSTW_CS_EXT_RISE 3'h7

`endif

// *** hw/dstw_prescaler.v ***
// Timer tick generator: divided clock enable or external edge
`timescale 1ns/1ps
`include "dstw_defs.vh"

module dstw_prescaler (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // Control
  input wire [2:0] i_clock_select,
  input wire i_ext_clk,
  // Tick
  output wire o_tick
);

  reg [9:0] div_reg;
  reg ext_prev_reg;
  reg tick_reg;
  reg tick_next;

  assign o_tick = tick_reg;

  // ----------------------------------------------------------------
  // Free running divider, ticks are enables not clocks
  // ----------------------------------------------------------------
  always @* begin
    case (i_clock_select)
      `DSTW_CS_DIV1: tick_next = 1'b1;
      `DSTW_CS_DIV8: tick_next = (div_reg[2:0] == `DSTW_DIV_8); // R20 R22
      `DSTW_CS_DIV64: tick_next = (div_reg[5:0] == `DSTW_DIV_64); // R20 R22
      `DSTW_CS_DIV256: tick_next = (div_reg[7:0] == `DSTW_DIV_256); // R20 R22
      `DSTW_CS_DIV1024: tick_next = (div_reg == `DSTW_DIV_1024); // R20 R22
      `DSTW_CS_EXT_FALL: tick_next = ext_prev_reg & ~i_ext_clk; // R22
      `DSTW_CS_EXT_RISE: tick_next = ~ext_prev_reg & i_ext_clk; // R22
      default: tick_next = 1'b0;
    endcase
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_reg <= 10'h000;
      ext_prev_reg <= 1'b0;
      tick_reg <= 1'b0;
    end else begin
      div_reg <= div_reg + 10'h001;
      ext_prev_reg <= i_ext_clk;
      tick_reg <= tick_next; // R19
    end
  end

endmodule

// *** hw/dstw_wave_unit.v ***
// One compare output unit: output register and pin hand-over decode
`timescale 1ns/1ps

module dstw_wave_unit (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // Configuration
  input wire [1:0] i_out_mode,
  input wire i_tog_ok,
  input wire i_nonpwm,
  input wire i_fast,
  input wire i_dual,
  // Events
  input wire i_match,
  input wire i_up_ctx,
  input wire i_bottom,
  input wire i_ocr_eq_top,
  input wire i_force,
  // Result
  output wire o_wave,
  output wire o_connected
);

  reg wave_reg;
  reg wave_next;

  assign o_wave = wave_reg;
  // Mode 1 only counts when toggling is allowed here
  assign o_connected = (i_out_mode != 2'h0) && (i_out_mode != 2'h1 || i_tog_ok); // R13 R14

  // ----------------------------------------------------------------
  // Output action
  // ----------------------------------------------------------------
  always @* begin
    wave_next = wave_reg;
    if (i_nonpwm) begin
      if (i_match || i_force) begin // R23
        case (i_out_mode)
          2'h1: wave_next = ~wave_reg; // R15
          2'h2: wave_next = 1'b0; // R15
          2'h3: wave_next = 1'b1; // R15
          default: wave_next = wave_reg;
        endcase
      end
    end else if (i_fast) begin
      if (i_out_mode[1]) begin
        if (i_bottom) begin
          wave_next = ~i_out_mode[0]; // R16
        end else if (i_match && !i_ocr_eq_top) begin
          wave_next = i_out_mode[0]; // R16 R17
        end
      end else if (i_out_mode[0] && i_tog_ok && i_match) begin
        wave_next = ~wave_reg; // R16
      end
    end else if (i_dual) begin
      if (i_out_mode[1] && i_match) begin
        // Bottom counts as rising, top as falling: keeps 0 and TOP solid
        wave_next = i_up_ctx ? i_out_mode[0] : ~i_out_mode[0]; // R5 R6 R12
      end else if (i_out_mode == 2'h1 && i_tog_ok && i_match) begin
        wave_next = ~wave_reg; // R11 R18
      end
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wave_reg <= 1'b0;
    end else begin
      wave_reg <= wave_next;
    end
  end

endmodule

// *** sim/dstw_load_model.sv ***
// Load on the two compare pins: what a motor driver input sees
`timescale 1ns/1ps
module dstw_load_model (
  // Pins from the device
  input wire logic i_pin_a,
  input wire logic i_oe_a_n,
  input wire logic i_pin_b,
  input wire logic i_oe_b_n,
  // Levels seen by the load
  output wire logic o_level_a,
  output wire logic o_level_b
);
  // Undriven input is pulled down, so a stale level can never pass for a drive
  assign o_level_a = i_oe_a_n ? 1'b0 : i_pin_a;
  assign o_level_b = i_oe_b_n ? 1'b0 : i_pin_b;
endmodule

// *** sim/dstw_top_props.sv ***
// Port assertions for the waveform generator top
`timescale 1ns/1ps
module dstw_top_props (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // APB
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [31:0] o_prdata,
  input wire o_pready,
  input wire o_pslverr,
  // Pins
  input wire i_ext_clk,
  input wire o_wave_pin_a,
  input wire o_wave_pin_a_oe_n,
  input wire o_wave_pin_b,
  input wire o_wave_pin_b_oe_n
);
  wire port_wr = i_psel && i_penable && i_pwrite && i_paddr == 8'h1c;
  wire rd_ok = o_pready && !i_pwrite;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // ----------------
  // Bus handshake
  // ----------------
  property p_setup_ready;
    i_psel && !i_penable |=> o_pready;
  endproperty
  a_setup_ready: assert property (p_setup_ready) else $error("ready missing after setup");
  property p_ready_access;
    o_pready |-> i_psel && i_penable;
  endproperty
  a_ready_access: assert property (p_ready_access) else $error("ready outside access");
  property p_ready_single;
    o_pready |=> !o_pready;
  endproperty
  a_ready_single: assert property (p_ready_single) else $error("ready held two cycles");
  property p_err_ready;
    o_pslverr |-> o_pready && o_prdata == 32'h0;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready or zero data");
  property p_unmapped;
    o_pready && i_paddr > 8'h1c |-> o_pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_mapped;
    o_pready && i_paddr <= 8'h1c && i_paddr[1:0] == 2'h0 |-> !o_pslverr;
  endproperty
  a_mapped: assert property (p_mapped) else $error("mapped access refused");
  // ----------------
  // Register and pin effects
  // ----------------
  property p_force_zero;
    rd_ok && i_paddr == 8'h00 |-> o_prdata[3:2] == 2'h0;
  endproperty
  a_force_zero: assert property (p_force_zero) else $error("force strobes read nonzero");
  property p_flags_upper;
    rd_ok && i_paddr == 8'h18 |-> o_prdata[31:5] == 27'h0;
  endproperty
  a_flags_upper: assert property (p_flags_upper) else $error("flag upper bits nonzero");
  property p_drive_cause;
    $fell(o_wave_pin_a_oe_n) || $fell(o_wave_pin_b_oe_n) |-> $past(port_wr) || $past(port_wr, 2);
  endproperty
  a_drive_cause: assert property (p_drive_cause) else $error("pin drive without port write");
endmodule
bind dstw_top dstw_top_props props_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_ext_clk(i_ext_clk),
  .o_wave_pin_a(o_wave_pin_a), .o_wave_pin_a_oe_n(o_wave_pin_a_oe_n),
  .o_wave_pin_b(o_wave_pin_b), .o_wave_pin_b_oe_n(o_wave_pin_b_oe_n));

// *** sim/dstw_top_bench.sv ***
// Self-checking bench for the dual-slope waveform generator
`timescale 1ns/1ps
module dstw_top_bench;
  typedef struct {logic [3:0] mode; logic [2:0] cs; int div; logic [15:0] top;
    logic [15:0] cmpb; logic [1:0] oma; logic [1:0] omb; int exp_a; int exp_b;} dstw_row_t;
  logic i_clk, i_rst_n, i_psel, i_penable, i_pwrite, i_ext_clk, err;
  logic [7:0] i_paddr;
  logic [31:0] i_pwdata, rd, ha, hb;
  wire [31:0] o_prdata;
  wire o_pready, o_pslverr, pin_a, oe_a_n, pin_b, oe_b_n, lvl_a, lvl_b;
  int fails, check_count;
  // Port data A is 1, so a disconnected A shows high for the whole window
  dstw_row_t rows[6] = '{
    '{4'h9, 3'h1, 1, 16'h8, 16'h3, 2'h0, 2'h2, 32, 12},
    '{4'h9, 3'h1, 1, 16'h8, 16'h3, 2'h1, 2'h3, 16, 20},
    '{4'h8, 3'h1, 1, 16'h5, 16'h2, 2'h2, 2'h2, 20, 8},
    '{4'h8, 3'h1, 1, 16'h3, 16'h0, 2'h1, 2'h2, 12, 0},
    '{4'h9, 3'h1, 1, 16'h3, 16'h3, 2'h3, 2'h2, 0, 12},
    '{4'h9, 3'h2, 8, 16'h4, 16'h1, 2'h0, 2'h2, 128, 32}};
  dstw_top dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_ext_clk(i_ext_clk),
    .o_wave_pin_a(pin_a), .o_wave_pin_a_oe_n(oe_a_n), .o_wave_pin_b(pin_b),
    .o_wave_pin_b_oe_n(oe_b_n));
  dstw_load_model load_u (.i_pin_a(pin_a), .i_oe_a_n(oe_a_n), .i_pin_b(pin_b),
    .i_oe_b_n(oe_b_n), .o_level_a(lvl_a), .o_level_b(lvl_b));
  // ----------------
  // Tasks
  // ----------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Entered just after an edge; leaves one idle cycle so psel never flips twice in a step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    cmp(n, 32'h1, "ready latency");
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic print_verdict;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ----------------
  // Clock, watchdog, sequence
  // ----------------
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    fails++;
    print_verdict;
  end
  initial begin
    {i_psel, i_penable, i_pwrite, i_ext_clk, i_rst_n} = 5'h0;
    i_paddr = 8'h0;
    i_pwdata = 32'h0;
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    for (int a = 0; a < 32; a += 4) begin
      apb(1'b0, 8'(a), 32'h0);
      cmp(rd, 32'h0, "reset value");
    end
    apb(1'b0, 8'h20, 32'h0);
    cmp({rd[30:0], err}, 32'h1, "unmapped read");
    apb(1'b1, 8'h1c, 32'h7);
    foreach (rows[i]) begin
      apb(1'b1, 8'h04, 32'h0);
      apb(1'b1, 8'h08, 32'h0);
      apb(1'b1, 8'h0c, {16'h0, rows[i].top});
      apb(1'b1, 8'h10, {16'h0, rows[i].cmpb});
      apb(1'b1, 8'h14, {16'h0, rows[i].top});
      apb(1'b1, 8'h00, {24'h0, rows[i].oma, rows[i].omb, 2'h0, rows[i].mode[1:0]});
      apb(1'b1, 8'h04, {27'h0, rows[i].mode[3:2], rows[i].cs});
      repeat (8 * rows[i].top * rows[i].div + 20) @(posedge i_clk);
      ha = 32'h0;
      hb = 32'h0;
      repeat (4 * rows[i].top * rows[i].div) begin
        @(posedge i_clk);
        ha = ha + lvl_a;
        hb = hb + lvl_b;
      end
      cmp(ha, 32'(rows[i].exp_a), "pin a high time");
      cmp(hb, 32'(rows[i].exp_b), "pin b high time");
    end
    // Compare above TOP, then TOP from the capture register
    apb(1'b1, 8'h10, 32'h6);
    repeat (300) @(posedge i_clk);
    apb(1'b1, 8'h18, 32'hf);
    repeat (300) @(posedge i_clk);
    apb(1'b0, 8'h18, 32'h0);
    cmp(rd & 32'hf, 32'h3, "flags with compare above top");
    apb(1'b1, 8'h00, 32'h20);
    apb(1'b1, 8'h18, 32'hf);
    repeat (300) @(posedge i_clk);
    apb(1'b0, 8'h18, 32'h0);
    cmp(rd & 32'hf, 32'hb, "flags with capture top");
    // External edge ticks only; the counter must not run on its own
    apb(1'b1, 8'h04, 32'h10);
    apb(1'b1, 8'h08, 32'h0);
    apb(1'b1, 8'h04, 32'h17);
    repeat (10) @(posedge i_clk);
    apb(1'b0, 8'h08, 32'h0);
    cmp(rd, 32'h0, "count idle without edges");
    repeat (2) begin
      i_ext_clk <= 1'b1;
      repeat (4) @(posedge i_clk);
      i_ext_clk <= 1'b0;
      repeat (4) @(posedge i_clk);
    end
    apb(1'b0, 8'h08, 32'h0);
    cmp(rd, 32'h2, "count after two edges");
    // Drivers off, then A driven from its port bit while its wave is disconnected
    apb(1'b1, 8'h1c, 32'h4);
    repeat (2) @(posedge i_clk);
    cmp({lvl_a, lvl_b}, 32'h0, "levels with drivers off");
    apb(1'b1, 8'h1c, 32'h5);
    repeat (2) @(posedge i_clk);
    cmp({lvl_a, lvl_b}, 32'h2, "level a from port data");
    // Reset in mid-run must clear written state and release the pins
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    cmp({lvl_a, lvl_b}, 32'h0, "levels after reset");
    apb(1'b0, 8'h1c, 32'h0);
    cmp(rd, 32'h0, "port after reset");
    apb(1'b0, 8'h08, 32'h0);
    cmp(rd, 32'h0, "count after reset");
    print_verdict;
  end
endmodule
